// File: rtl/fpac_map.svh
// register map, field positions, reset value and timing figures of the fan smoothing block
// assumes inclusion by the package and the design modules only
`ifndef FPAC_MAP_SVH
`define FPAC_MAP_SVH
`define FPAC_CTRL_ADDR 8'h62
`define FPAC_CTRL_RST 8'h20
`define FPAC_RATE_LSB 0
`define FPAC_RATE_MSB 2
`define FPAC_SMOOTH_BIT 3
`define FPAC_GROUP_BIT 4
`define FPAC_HOLD_LSB 5
`define FPAC_INC0 8'h01
`define FPAC_INC1 8'h02
`define FPAC_INC2 8'h03
`define FPAC_INC3 8'h04
`define FPAC_INC4 8'h08
`define FPAC_INC5 8'h0c
`define FPAC_INC6 8'h18
`define FPAC_INC7 8'h30
// full 0% to 100% ramp at the slowest code, 37.5 s, in ms
`define FPAC_FULL_RAMP_MS 64'd37500
`define FPAC_CLK_KHZ 64'd100000
`define FPAC_DUTY_STEPS 64'd255
`define FPAC_DUTY_ZERO 8'h00
`define FPAC_SLOT_W 24
`endif

// File: rtl/fpac_pkg.sv
// types shared by the fan smoothing block
// assumes fpac_map.svh is on the include path
`include "fpac_map.svh"
package fpac_pkg;
	typedef logic [7:0] fpac_duty_t;
	typedef logic [2:0] fpac_rate_t;
	// control register fields, msb first
	typedef struct packed {
		logic [2:0] floorHold; // out3, out2, out1
		logic tachGroup;
		logic smoothEn;
		fpac_rate_t rate;
	} fpac_ctrl_t;
	// increment per time slot for a ramp-rate code
	function automatic fpac_duty_t fpac_rate_inc_t(input fpac_rate_t code);
		case (code)
			3'h0: fpac_rate_inc_t = `FPAC_INC0;
			3'h1: fpac_rate_inc_t = `FPAC_INC1;
			3'h2: fpac_rate_inc_t = `FPAC_INC2;
			3'h3: fpac_rate_inc_t = `FPAC_INC3;
			3'h4: fpac_rate_inc_t = `FPAC_INC4;
			3'h5: fpac_rate_inc_t = `FPAC_INC5;
			3'h6: fpac_rate_inc_t = `FPAC_INC6;
			default: fpac_rate_inc_t = `FPAC_INC7;
		endcase
	endfunction : fpac_rate_inc_t
endpackage : fpac_pkg

// File: rtl/fpac_ramp.sv
// output-1 duty ramp stepper: follows the target on the next clock with smoothing off, else steps toward it once per time slot
// assumes target arrives on clk; slot length is a parameter so simulation can shorten it
`timescale 1ns/100ps
`include "fpac_map.svh"
module fpac_ramp import fpac_pkg::*; #(
	parameter int unsigned SLOT_CYCLES = int'((`FPAC_FULL_RAMP_MS * `FPAC_CLK_KHZ) / `FPAC_DUTY_STEPS)
) (
	input wire logic clk,
	input wire logic sys_rst,
	fpac_ramp_if.ramp rp
);
	typedef struct packed {
		logic [`FPAC_SLOT_W-1:0] slotCnt; // cycles into current slot
		fpac_duty_t duty; // driven duty
	} fpac_ramp_st_t;
	fpac_ramp_st_t st_q, st_d;
	fpac_duty_t inc; // step for current code
	logic slotEnd; // last cycle of a slot
	// slot timer and stepping
	always_comb begin
		inc = fpac_rate_inc_t(rp.rate);
		slotEnd = (st_q.slotCnt == `FPAC_SLOT_W'(SLOT_CYCLES - 1));
		st_d = st_q;
		st_d.slotCnt = slotEnd ? '0 : st_q.slotCnt + `FPAC_SLOT_W'(1);
		if (!rp.smoothEn) begin
			st_d.duty = rp.target;
		end else if (slotEnd) begin
			// clamp the last step so the target is never overshot
			if (st_q.duty < rp.target) begin
				st_d.duty = ((rp.target - st_q.duty) > inc) ? st_q.duty + inc : rp.target;
			end else if (st_q.duty > rp.target) begin
				st_d.duty = ((st_q.duty - rp.target) > inc) ? st_q.duty - inc : rp.target;
			end
		end
	end
	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign rp.duty = st_q.duty;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_bypass_direct: assert property (!rp.smoothEn |=> rp.duty == $past(rp.target))
		else $error("duty did not follow target with smoothing off");
	chk_hold_between_slots: assert property (rp.smoothEn && !slotEnd |=> $stable(rp.duty))
		else $error("duty moved inside a time slot");
	chk_step_up_size: assert property (rp.smoothEn && slotEnd && rp.duty < rp.target
		|=> rp.duty == (($past(rp.target) - $past(rp.duty)) > $past(inc) ? $past(rp.duty) + $past(inc)
		: $past(rp.target)))
		else $error("upward step size wrong");
	chk_step_down_size: assert property (rp.smoothEn && slotEnd && rp.duty > rp.target
		|=> rp.duty == (($past(rp.duty) - $past(rp.target)) > $past(inc) ? $past(rp.duty) - $past(inc)
		: $past(rp.target)))
		else $error("downward step size wrong");
endmodule : fpac_ramp

// File: rtl/fpac_ramp_if.sv
// carrier between the control top and the output-1 ramp stepper
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface fpac_ramp_if;
	import fpac_pkg::*;
	fpac_duty_t target; // floored duty wanted
	logic smoothEn; // ramp instead of jump
	fpac_rate_t rate; // increment code
	fpac_duty_t duty; // duty driven now
	modport ctl (output target, output smoothEn, output rate, input duty);
	modport ramp (input target, input smoothEn, input rate, output duty);
endinterface : fpac_ramp_if

// File: rtl/fpac_top.sv
// fan smoothing and floor control: one control register, output floors, output-1 ramp, tach grouping
// assumes the serial slave port decodes frames and presents byte strobes on clk; temp logic is on clk
//
// Contract
// - bits 2:0 limit output-1 duty change rate
// - codes step 1,2,3,4,8,12,24,48 per slot
// - smoothing only while bit 3 set
// - grouping set: speed inputs 2,3,4 follow out3
// - grouping clear: only inputs 3,4 follow out3
// - out1 below start: zero or minimum by bit5
// - out2 below start: zero or minimum by bit6
// - out3 below start: zero or minimum by bit7
// - register read/write, resets to 0x20
`timescale 1ns/100ps
`include "fpac_map.svh"
module fpac_top import fpac_pkg::*; #(
	parameter int unsigned SLOT_CYCLES = int'((`FPAC_FULL_RAMP_MS * `FPAC_CLK_KHZ) / `FPAC_DUTY_STEPS)
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr, // register pointer from slave port
	input wire logic [7:0] regWrData, // byte to store
	input wire logic regWrEn, // one-cycle write strobe
	input wire logic regRdEn, // one-cycle read strobe
	output logic [7:0] regRdData, // read byte, registered
	output logic regRdValid, // one-cycle read answer
	input wire logic autoMode, // automatic fan control active
	input wire logic [2:0] belowStart, // per output: temp below start minus hysteresis
	input wire logic [23:0] dutyCalc, // computed duty, out3 in [23:16]
	input wire logic [23:0] dutyMin, // programmed minimum duty, out3 in [23:16]
	input wire logic fan_speed_in2, // tach pins, asynchronous
	input wire logic fan_speed_in3,
	input wire logic fan_speed_in4,
	output logic [2:0] speedSyncOut3, // inputs 4..2 measured against out3
	output logic [2:0] speedLevel, // synchronised tach levels 4..2
	output logic [7:0] fan_drive_out1, // duty of output 1
	output logic [7:0] fan_drive_out2,
	output logic [7:0] fan_drive_out3
);
	typedef struct packed {
		fpac_ctrl_t ctrl; // control register
		logic [7:0] rdData; // read answer byte
		logic rdValid; // read answer strobe
		fpac_duty_t duty2; // output-2 duty
		fpac_duty_t duty3; // output-3 duty
		logic [2:0] syncA; // first tach stage, read only by syncB
		logic [2:0] syncB; // second tach stage
	} fpac_top_st_t;
	fpac_top_st_t st_q, st_d;
	fpac_duty_t floored [3]; // duty after floor decision
	logic hit; // pointer matches our register
	fpac_ramp_if rif ();

	// floor decision, same for every output
	for (genvar i = 0; i < 3; i++) begin : g_floor
		always_comb begin
			if (autoMode && belowStart[i]) begin
				floored[i] = st_q.ctrl.floorHold[i] ? dutyMin[8*i +: 8] : `FPAC_DUTY_ZERO;
			end else begin
				floored[i] = dutyCalc[8*i +: 8];
			end
		end
	end

	// register access, output 2/3 update, tach sampling
	always_comb begin
		hit = (regAddr == `FPAC_CTRL_ADDR);
		st_d = st_q;
		st_d.rdValid = regRdEn;
		if (regWrEn && hit) begin
			st_d.ctrl = fpac_ctrl_t'(regWrData);
		end
		if (regRdEn) begin
			// unmapped pointers read zero; other registers live elsewhere
			st_d.rdData = hit ? st_q.ctrl : 8'h00;
		end
		st_d.duty2 = floored[1];
		st_d.duty3 = floored[2];
		st_d.syncA = {fan_speed_in4, fan_speed_in3, fan_speed_in2};
		st_d.syncB = st_q.syncA;
	end
	// state register, power-on value of the control byte
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= '0;
			st_q.ctrl <= fpac_ctrl_t'(`FPAC_CTRL_RST);
		end else begin
			st_q <= st_d;
		end
	end

	// output-1 path goes through the ramp stepper
	assign rif.target = floored[0];
	assign rif.smoothEn = st_q.ctrl.smoothEn;
	assign rif.rate = st_q.ctrl.rate;
	fpac_ramp #(.SLOT_CYCLES(SLOT_CYCLES)) u_ramp (
		.clk(clk),
		.sys_rst(sys_rst),
		.rp(rif.ramp)
	);

	// inputs 3 and 4 always follow out3; input 2 only when grouped
	assign speedSyncOut3 = {2'b11, st_q.ctrl.tachGroup};
	assign speedLevel = st_q.syncB;
	assign regRdData = st_q.rdData;
	assign regRdValid = st_q.rdValid;
	assign fan_drive_out1 = rif.duty;
	assign fan_drive_out2 = st_q.duty2;
	assign fan_drive_out3 = st_q.duty3;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_write_hit;
		regWrEn && regAddr == `FPAC_CTRL_ADDR;
	endsequence
	sequence s_read_back;
		regRdEn && regAddr == `FPAC_CTRL_ADDR && !regWrEn;
	endsequence
	chk_write_then_read: assert property (s_write_hit ##1 s_read_back |=> regRdValid
		&& regRdData == $past(regWrData, 2))
		else $error("control byte not read back as written");
	chk_reset_value: assert property (@(posedge clk) $fell(sys_rst) |-> st_q.ctrl == `FPAC_CTRL_RST)
		else $error("control byte not at power-on value");
	chk_group_on: assert property (st_q.ctrl.tachGroup |-> speedSyncOut3 == 3'h7)
		else $error("grouping set but input 2 not on out3");
	chk_group_off: assert property (!st_q.ctrl.tachGroup |-> speedSyncOut3 == 3'h6)
		else $error("grouping clear but input 2 on out3");
	chk_out2_floor: assert property (autoMode && belowStart[1]
		|=> fan_drive_out2 == ($past(st_q.ctrl.floorHold[1]) ? $past(dutyMin[15:8]) : 8'h00))
		else $error("output 2 floor wrong");
	chk_out3_floor: assert property (autoMode && belowStart[2]
		|=> fan_drive_out3 == ($past(st_q.ctrl.floorHold[2]) ? $past(dutyMin[23:16]) : 8'h00))
		else $error("output 3 floor wrong");
	chk_out1_floor: assert property (autoMode && belowStart[0] && !st_q.ctrl.smoothEn
		|=> fan_drive_out1 == ($past(st_q.ctrl.floorHold[0]) ? $past(dutyMin[7:0]) : 8'h00))
		else $error("output 1 floor wrong");
	chk_out2_normal: assert property (!autoMode |=> fan_drive_out2 == $past(dutyCalc[15:8]))
		else $error("output 2 not following computed duty");
endmodule : fpac_top

// File: verif/fpac_fan_model.sv
// cooling fans hung on drive output 3, giving tach levels back to the block
// assumes one clock; tach rate is arbitrary and not tied to the duty value
`timescale 1ns/100ps
module fpac_fan_model (
	input wire logic clk,
	input wire logic [7:0] drive, // duty seen by the fans
	output logic [2:0] tach = 3'b111 // fans on inputs 4..2
);
	logic [3:0] phase_q = 4'h0; // free-running tach phase
	// a stopped fan leaves its open-drain tach at the pull-up level
	always @(posedge clk) begin
		phase_q <= phase_q + 4'h1;
		tach <= (drive == 8'h00) ? 3'b111 : {3{phase_q[3]}};
	end
endmodule : fpac_fan_model

// File: verif/test_fan_pwm_acoustic_control.sv
// self-checking bench for the fan smoothing and floor control block
// assumes the design files and the fan model are compiled first
`timescale 1ns/100ps
module test_fan_pwm_acoustic_control;
	import fpac_pkg::*;
	localparam int unsigned SLOT = 4; // short time slot keeps the run brief
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [7:0] regRdData;
	logic regRdValid;
	logic autoMode = 1'b0;
	logic [2:0] belowStart = 3'h0;
	logic [23:0] dutyCalc = 24'h000000;
	logic [23:0] dutyMin = 24'h000000;
	logic [2:0] tach; // from the fans
	logic [2:0] speedSyncOut3;
	logic [2:0] speedLevel; // synchronised tach levels back from the block
	logic [7:0] out1, out2, out3;
	int fails = 0;
	int n_tests = 0;
	int cycles = 0;
	int incTab [8] = '{1, 2, 3, 4, 8, 12, 24, 48}; // step per slot by code
	always #5 clk = ~clk;
	fpac_top #(.SLOT_CYCLES(SLOT)) i_fpac_top (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .autoMode(autoMode), .belowStart(belowStart), .dutyCalc(dutyCalc),
		.dutyMin(dutyMin), .fan_speed_in2(tach[0]), .fan_speed_in3(tach[1]), .fan_speed_in4(tach[2]),
		.speedSyncOut3(speedSyncOut3), .speedLevel(speedLevel), .fan_drive_out1(out1), .fan_drive_out2(out2),
		.fan_drive_out3(out3));
	fpac_fan_model i_fpac_fan_model (.clk(clk), .drive(out3), .tach(tach));
	// hang guard: the whole sequence needs far fewer cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			fails++;
			conclude();
		end
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] expv);
		n_tests++;
		if (seen !== expv) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expv);
		end
	endtask : check
	task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
		#1; // let the stored byte settle before anyone looks
	endtask : wrReg
	// answer lands on the edge that samples the read strobe, looked at once just after it
	task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1;
		check({23'h0, regRdValid}, 24'h000001);
		d = regRdData;
	endtask : rdReg
	// duty path inputs, then two edges for the registered outputs
	task automatic drive(input logic m, input logic [2:0] b, input logic [23:0] c);
		@(posedge clk);
		autoMode <= m;
		belowStart <= b;
		dutyCalc <= c;
		repeat (2) @(posedge clk);
		#1;
	endtask : drive
	task automatic tRegAccess;
		logic [7:0] v;
		rdReg(8'h62, v);
		check({16'h0, v}, 24'h000020);
		check({21'h0, speedLevel}, 24'h000007);
		check({21'h0, speedSyncOut3}, 24'h000006);
		wrReg(8'h62, 8'h5a);
		rdReg(8'h62, v);
		check({16'h0, v}, 24'h00005a);
		check({21'h0, speedSyncOut3}, 24'h000007);
		wrReg(8'h61, 8'hff); // unmapped write is dropped
		rdReg(8'h62, v);
		check({16'h0, v}, 24'h00005a);
		rdReg(8'h61, v);
		check({16'h0, v}, 24'h000000);
		// write then read on the very next edge must see the new byte
		@(posedge clk);
		regAddr <= 8'h62;
		regWrData <= 8'ha5;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1;
		check({15'h0, regRdValid, regRdData}, 24'h0001a5);
		wrReg(8'h62, 8'h00);
		check({21'h0, speedSyncOut3}, 24'h000006);
	endtask : tRegAccess
	// each hold bit seen both set and clear against its neighbours
	task automatic tFloor;
		logic [2:0] pats [2] = '{3'b010, 3'b101};
		dutyMin <= 24'h302010;
		foreach (pats[i]) begin
			wrReg(8'h62, {pats[i], 5'h00});
			drive(1'b1, 3'b111, 24'h807060);
			check({16'h0, out1}, pats[i][0] ? 24'h10 : 24'h0);
			check({16'h0, out2}, pats[i][1] ? 24'h20 : 24'h0);
			check({16'h0, out3}, pats[i][2] ? 24'h30 : 24'h0);
		end
		drive(1'b1, 3'b000, 24'h807060);
		check({out3, out2, out1}, 24'h807060);
		drive(1'b0, 3'b111, 24'h605040);
		check({out3, out2, out1}, 24'h605040);
	endtask : tFloor
	// every code ramps 0 toward 100 over three steps; only code 7 meets the clamp, on its third step
	task automatic tRamp;
		int k;
		for (int c = 0; c < 8; c++) begin
			wrReg(8'h62, 8'h00);
			drive(1'b0, 3'b000, 24'h000000);
			check({16'h0, out1}, 24'h000000);
			wrReg(8'h62, 8'h08 | 8'(c));
			dutyCalc <= 24'h000064;
			k = 0;
			do begin
				@(posedge clk);
				#1;
				k++;
			end while (out1 === 8'h00 && k < 12);
			check({16'h0, out1}, 24'(incTab[c]));
			for (int n = 2; n < 4; n++) begin
				repeat (SLOT) @(posedge clk);
				#1;
				check({16'h0, out1}, 24'((n * incTab[c] > 100) ? 100 : n * incTab[c]));
			end
		end
		wrReg(8'h62, 8'h07); // code kept, smoothing off
		drive(1'b0, 3'b000, 24'h0000c8);
		check({16'h0, out1}, 24'h0000c8);
	endtask : tRamp
	task automatic conclude;
		$display("comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		tRegAccess();
		tFloor();
		tRamp();
		conclude();
	end
endmodule : test_fan_pwm_acoustic_control
